// file: shared/dcs_pkg.sv
// constants, types and register map of the dual-sample conversion sequencer
// assumes a 100 MHz system clock; all timing counts derive from CLK_NS
package dcs_pkg;
  localparam int CLK_NS = 10;
  localparam int CW = 12;
  // conversion timing, ns
  localparam int T_CONV_A_NS = 700;
  localparam int T_CONV_A_IMP_NS = 950;
  localparam int T_CONV_B_NS = 700;
  localparam int T_EOC_GAP_NS = 45;
  localparam int T_DATA_BUSY_NS = 14;
  localparam int T_SYNC_RDC_NS = 250;
  localparam int T_SYNC_RDC_IMP_NS = 500;
  localparam int T_SYNC_RAC_NS = 750;
  localparam int T_SYNC_RAC_IMP_NS = 1000;
  localparam int T_SYNC_BUSY_NS = 25;
  localparam int T_LEAD0_NS = 3;
  localparam int T_LEAD_NS = 17;
  localparam int T_BUSY_MAX_NS = 1750;
  localparam int T_BUSY_MAX_IMP_NS = 2000;
  localparam int T_EOC_A_MAX_NS = 1000;
  localparam int T_EOC_A_MAX_IMP_NS = 1250;
  localparam int T_EOC_B_MAX_NS = 750;
  localparam int SCLK_NS [4] = '{40, 70, 140, 280};
  // cycle counts: longest times round down, least times round up
  localparam logic [CW-1:0] CONV_A_CYC = CW'(T_CONV_A_NS / CLK_NS);
  localparam logic [CW-1:0] CONV_A_IMP_CYC = CW'(T_CONV_A_IMP_NS / CLK_NS);
  localparam logic [CW-1:0] CONV_B_CYC = CW'(T_CONV_B_NS / CLK_NS);
  localparam logic [CW-1:0] GAP_CYC = CW'((T_EOC_GAP_NS + CLK_NS - 1) / CLK_NS);
  // one extra cycle: the parallel data register trails the result capture
  localparam logic [CW-1:0] TAIL_CYC = CW'((T_DATA_BUSY_NS + CLK_NS - 1) / CLK_NS + 1);
  localparam logic [CW-1:0] SYNC_RDC_CYC = CW'(T_SYNC_RDC_NS / CLK_NS);
  localparam logic [CW-1:0] SYNC_RDC_IMP_CYC = CW'(T_SYNC_RDC_IMP_NS / CLK_NS);
  localparam logic [CW-1:0] SYNC_RAC_CYC = CW'(T_SYNC_RAC_NS / CLK_NS);
  localparam logic [CW-1:0] SYNC_RAC_IMP_CYC = CW'(T_SYNC_RAC_IMP_NS / CLK_NS);
  localparam logic [CW-1:0] POST_CYC = CW'((T_SYNC_BUSY_NS + CLK_NS - 1) / CLK_NS - 1);
  // wishbone register map
  localparam int WB_AW = 8;
  localparam logic [WB_AW-1:0] REG_CTRL = 8'h00;
  localparam logic [WB_AW-1:0] REG_STATUS = 8'h04;
  localparam logic [WB_AW-1:0] REG_RES_A = 8'h08;
  localparam logic [WB_AW-1:0] REG_RES_B = 8'h0c;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int CTRL_PORT_BIT = 0;
  localparam int CTRL_LP_BIT = 1;
  localparam int CTRL_SLAVE_BIT = 2;
  localparam int CTRL_RAC_BIT = 3;
  localparam int CTRL_DIV_LSB = 4;
  localparam int CTRL_PAIR_BIT = 6;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_EOC_BIT = 1;
  localparam int STAT_PAIR_BIT = 2;
  localparam int STAT_SYNC_BIT = 3;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [WB_AW-1:0] adr;
    logic [31:0] dat;
  } dcs_wb_req_s;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } dcs_wb_rsp_s;
  typedef enum logic [2:0] {C_IDLE, C_A, C_GAP, C_B, C_TAIL} dcs_conv_e;
  typedef enum logic [2:0] {S_IDLE, S_DELAY, S_WAIT, S_LEAD, S_HIGH, S_LOW, S_END, S_POST} dcs_ser_e;
endpackage

// file: rtl/dcs_sequencer.sv
// conversion sequencer with parallel, master serial and slave serial result ports
// assumes host pins come from logic on clk and the analog core holds results steady
//
// Local design decisions: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ns
// Functional notes
// - busy rises within 32 ns of convert start falling.
// - busy high at most 1.75/2 us except master read-after-convert.
// - busy falls at least 10 ns after both conversions end.
// - end-of-conversion flag rises within 30 ns of convert start.
// - flag high during channel A at most 1/1.25 us.
// - flag low at least 45 ns between channel A and B.
// - flag high during channel B at most 0.75 us.
// - parallel result valid within 1.75/2 us of convert start.
// - parallel data valid at least 14 ns before busy falls.
// - bus request gives data within 40 ns, release 5 to 15 ns.
// - channel select change presents the other result within 40 ns.
// - read-during-convert frame sync about 250/500 ns after start.
// - read-after-convert frame sync about 0.75/1 us after start.
// - master serial busy falls about 25 ns after frame sync ends.
// - divider settings give serial clock periods of at least 25..200 ns.
// - typical serial clock periods 40, 70, 140, 280 ns.
// - normal read-after-convert busy at most 3.25..10.75 us.
// - reduced-power read-after-convert busy at most 3.5..11 us.
// - first serial clock edge 3 or 17 ns after frame sync.
// - chip select high floats sync, clock and serial data within 10 ns.
// - slave serial data updates 3 to 18 ns after clock edge.
// - input pair select low samples pair one, high pair two.
// - channel select high sends A then B, low B then A.
// - low power select uses reduced-power timings.
// - port select low parallel, high serial.
module dcs_sequencer
  import dcs_pkg::*;
#(
  parameter int RES_W = 16
) (
  input logic clk,
  input logic rstn,
  input logic ce,
  input dcs_wb_req_s wb_i,
  output dcs_wb_rsp_s wb_o,
  input logic convert_start_n,
  input logic conv_reset,
  input logic cs_n,
  input logic rd_n,
  input logic chan_read_sel,
  input logic ext_sclk,
  input logic serial_chain_in,
  input logic [RES_W-1:0] core_a_result,
  input logic [RES_W-1:0] core_b_result,
  output logic busy,
  output logic eoc,
  output logic pair_sel,
  output logic sample_hold,
  output logic [RES_W-1:0] par_data,
  output logic par_oe,
  output logic sync_out,
  output logic sync_oe,
  output logic sclk_out,
  output logic sclk_oe,
  output logic serial_result_out,
  output logic serial_result_out_oe
);
  localparam int FW = 2 * RES_W;

  logic [7:0] ctrl;
  dcs_conv_e cst, next_cst;
  dcs_ser_e sst, next_sst;
  logic [CW-1:0] ccnt, next_ccnt, scnt, next_scnt;
  logic [5:0] bitc;
  logic cnv_q, sclk_q, ser_done, b_done_q;
  logic [RES_W-1:0] res_a, res_b;
  logic [FW-1:0] shreg;
  logic [CW-1:0] hi_tab [4];
  logic [CW-1:0] lo_tab [4];
  logic [CW-1:0] lead_tab [4];
  logic wb_ack;
  logic [31:0] wb_dat;
  logic [31:0] status_w;

  // mode decode
  wire serial_mode = ctrl[CTRL_PORT_BIT];
  wire low_power = ctrl[CTRL_LP_BIT];
  wire slave_mode = serial_mode & ctrl[CTRL_SLAVE_BIT];
  wire master_mode = serial_mode & ~ctrl[CTRL_SLAVE_BIT];
  wire rac = ctrl[CTRL_RAC_BIT];
  // read-during-convert always runs the fastest serial clock
  wire [1:0] div = rac ? ctrl[CTRL_DIV_LSB +: 2] : 2'b00;

  // a start while busy is ignored; the host is expected not to try
  wire start = cnv_q & ~convert_start_n & (cst == C_IDLE) & ~conv_reset;
  wire [CW-1:0] conv_a_cyc = low_power ? CONV_A_IMP_CYC : CONV_A_CYC;
  wire [CW-1:0] sync_rdc = low_power ? SYNC_RDC_IMP_CYC : SYNC_RDC_CYC;
  wire [CW-1:0] sync_rac = low_power ? SYNC_RAC_IMP_CYC : SYNC_RAC_CYC;
  wire [CW-1:0] sync_cyc = rac ? sync_rac : sync_rdc;
  wire a_done = (cst == C_A) && (ccnt == '0);
  wire b_done = (cst == C_B) && (ccnt == '0);
  wire ser_fin = (sst == S_POST) && (scnt == '0);

  // serial clock shape per divider setting
  for (genvar g = 0; g < 4; g++) begin : g_div
    assign hi_tab[g] = CW'((SCLK_NS[g] / 2 + CLK_NS - 1) / CLK_NS);
    assign lo_tab[g] = CW'(SCLK_NS[g] / CLK_NS) - hi_tab[g];
    assign lead_tab[g] = CW'(((g == 0 ? T_LEAD0_NS : T_LEAD_NS) + CLK_NS - 1) / CLK_NS);
  end
  wire [CW-1:0] hi_cyc = hi_tab[div];
  wire [CW-1:0] lo_cyc = lo_tab[div];

  // conversion sequence: A, flag gap, B, data settle tail
  always_comb begin
    next_cst = cst;
    next_ccnt = (ccnt == '0) ? ccnt : ccnt - 1'b1;
    unique case (cst)
      C_IDLE: if (start) begin
        next_cst = C_A;
        next_ccnt = conv_a_cyc - 1'b1;
      end
      C_A: if (ccnt == '0) begin
        next_cst = C_GAP;
        next_ccnt = GAP_CYC - 1'b1;
      end
      C_GAP: if (ccnt == '0) begin
        next_cst = C_B;
        next_ccnt = CONV_B_CYC - 1'b1;
      end
      C_B: if (ccnt == '0) begin
        next_cst = C_TAIL;
        next_ccnt = TAIL_CYC - 1'b1;
      end
      C_TAIL: if (ccnt == '0 && (ser_done || !master_mode)) begin
        next_cst = C_IDLE;
      end
    endcase
    if (conv_reset) begin
      next_cst = C_IDLE;
    end
  end

  // master serial frame
  always_comb begin
    next_sst = sst;
    next_scnt = (scnt == '0) ? scnt : scnt - 1'b1;
    unique case (sst)
      S_IDLE: if (start && master_mode) begin
        next_sst = S_DELAY;
        next_scnt = sync_cyc - 2'd2;
      end
      S_DELAY: if (scnt == '0) begin
        next_sst = S_WAIT;
      end
      // after-convert frames hold the clock until both results exist
      S_WAIT: if (!rac || cst == C_TAIL) begin
        next_sst = S_LEAD;
        next_scnt = lead_tab[div] - 1'b1;
      end
      S_LEAD: if (scnt == '0) begin
        next_sst = S_HIGH;
        next_scnt = hi_cyc - 1'b1;
      end
      S_HIGH: if (scnt == '0) begin
        next_sst = (bitc == 6'(FW - 1)) ? S_END : S_LOW;
        next_scnt = lo_cyc - 1'b1;
      end
      S_LOW: if (scnt == '0) begin
        next_sst = S_HIGH;
        next_scnt = hi_cyc - 1'b1;
      end
      S_END: if (scnt == '0) begin
        next_sst = S_POST;
        next_scnt = POST_CYC - 1'b1;
      end
      S_POST: if (scnt == '0) begin
        next_sst = S_IDLE;
      end
    endcase
    if (conv_reset) begin
      next_sst = S_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cst <= C_IDLE;
      ccnt <= '0;
      busy <= 1'b0;
      eoc <= 1'b0;
    end else if (ce) begin
      cst <= next_cst;
      ccnt <= next_ccnt;
      busy <= next_cst != C_IDLE;
      eoc <= (next_cst == C_A) || (next_cst == C_B);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sst <= S_IDLE;
      scnt <= '0;
      sync_out <= 1'b0;
      sclk_out <= 1'b0;
      ser_done <= 1'b0;
    end else if (ce) begin
      sst <= next_sst;
      scnt <= next_scnt;
      sync_out <= next_sst inside {S_WAIT, S_LEAD, S_HIGH, S_LOW, S_END};
      sclk_out <= next_sst == S_HIGH;
      ser_done <= ser_fin | (ser_done & ~start);
    end
  end

  // sampling and result capture
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnv_q <= 1'b1;
      pair_sel <= 1'b0;
      sample_hold <= 1'b0;
      res_a <= '0;
      res_b <= '0;
      b_done_q <= 1'b0;
    end else if (ce) begin
      cnv_q <= convert_start_n;
      sample_hold <= start;
      b_done_q <= b_done;
      if (start) begin
        pair_sel <= ctrl[CTRL_PAIR_BIT];
      end
      if (a_done) begin
        res_a <= core_a_result;
      end
      if (b_done) begin
        res_b <= core_b_result;
      end
    end
  end

  // parallel port
  wire par_req = ~cs_n & ~rd_n & ~serial_mode;
  wire [RES_W-1:0] par_next = chan_read_sel ? res_a : res_b;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      par_data <= '0;
      par_oe <= 1'b0;
    end else if (ce) begin
      par_data <= par_next;
      par_oe <= par_req;
    end
  end

  // shared shifter: master frames and host-clocked slave reads
  wire [FW-1:0] frame = chan_read_sel ? {res_a, res_b} : {res_b, res_a};
  wire ld_m = (sst == S_WAIT) && (next_sst == S_LEAD);
  wire sh_m = (sst == S_HIGH) && (scnt == '0);
  wire sh_s = slave_mode & ~cs_n & ext_sclk & ~sclk_q;
  wire ld_s = slave_mode & b_done_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shreg <= '0;
      bitc <= '0;
      sclk_q <= 1'b0;
    end else if (ce) begin
      sclk_q <= ext_sclk;
      if (ld_m || ld_s) begin
        shreg <= frame;
      end else if (sh_m || sh_s) begin
        shreg <= {shreg[FW-2:0], serial_chain_in};
      end
      if (ld_m) begin
        bitc <= '0;
      end else if (sh_m) begin
        bitc <= bitc + 1'b1;
      end
    end
  end

  assign serial_result_out = shreg[FW-1];
  // enables stay combinational so chip select floats the pins at once
  wire ser_en = ~cs_n & serial_mode;
  assign serial_result_out_oe = ser_en;
  assign sync_oe = ser_en & master_mode;
  assign sclk_oe = ser_en & master_mode;

  // wishbone slave; every access, mapped or not, is acked after one cycle
  wire wb_go = wb_i.cyc & wb_i.stb & ~wb_ack;
  wire hit_ctrl = wb_i.adr == REG_CTRL;
  wire hit_stat = wb_i.adr == REG_STATUS;
  wire hit_ra = wb_i.adr == REG_RES_A;
  wire hit_rb = wb_i.adr == REG_RES_B;
  wire wr_ctrl = wb_go & wb_i.we & hit_ctrl & wb_i.sel[0];

  always_comb begin
    status_w = '0;
    status_w[STAT_BUSY_BIT] = busy;
    status_w[STAT_EOC_BIT] = eoc;
    status_w[STAT_PAIR_BIT] = pair_sel;
    status_w[STAT_SYNC_BIT] = sync_out;
  end

  wire [31:0] rd_mux = hit_ctrl ? {24'h0, ctrl} :
                       hit_stat ? status_w :
                       hit_ra ? 32'(res_a) :
                       hit_rb ? 32'(res_b) : 32'h0;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= CTRL_RESET;
      wb_ack <= 1'b0;
      wb_dat <= '0;
    end else if (ce) begin
      wb_ack <= wb_go;
      wb_dat <= (wb_go && !wb_i.we) ? rd_mux : 32'h0;
      if (wr_ctrl) begin
        ctrl <= wb_i.dat[7:0];
      end
    end
  end

  assign wb_o.ack = wb_ack;
  assign wb_o.dat = wb_dat;

  // checks
  localparam int BUSY_MAX_N = T_BUSY_MAX_NS / CLK_NS;
  localparam int BUSY_MAX_I = T_BUSY_MAX_IMP_NS / CLK_NS;
  localparam int EOC_A_MAX_N = T_EOC_A_MAX_NS / CLK_NS;
  localparam int EOC_A_MAX_I = T_EOC_A_MAX_IMP_NS / CLK_NS;
  localparam int EOC_B_MAX = T_EOC_B_MAX_NS / CLK_NS;
  logic [CW-1:0] busy_cnt, eoc_cnt;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_cnt <= '0;
      eoc_cnt <= '0;
    end else if (ce) begin
      busy_cnt <= busy ? busy_cnt + 1'b1 : '0;
      eoc_cnt <= eoc ? eoc_cnt + 1'b1 : '0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn || !ce);

  a_busy_rise:
    assert property (start |=> busy)
      else $error("busy did not rise after convert start");
  a_eoc_rise:
    assert property (start |=> eoc && cst == C_A)
      else $error("flag did not rise after convert start");
  a_busy_max:
    assert property (busy && !(master_mode && rac) |->
      busy_cnt < CW'(low_power ? BUSY_MAX_I : BUSY_MAX_N))
      else $error("busy high too long");
  a_busy_tail:
    assert property (b_done |=> busy [*2])
      else $error("busy fell too soon after conversion end");
  a_eoc_a_max:
    assert property (eoc && cst == C_A |->
      eoc_cnt < CW'(low_power ? EOC_A_MAX_I : EOC_A_MAX_N))
      else $error("flag high too long for channel A");
  a_eoc_gap:
    assert property ($fell(eoc) && cst == C_GAP |-> !eoc [*5])
      else $error("flag gap between channels too short");
  a_eoc_b_max:
    assert property (eoc && cst == C_B |-> eoc_cnt < CW'(EOC_B_MAX))
      else $error("flag high too long for channel B");
  a_data_before_busy:
    assert property (b_done && !serial_mode |->
      ##2 par_data == $past(chan_read_sel ? res_a : core_b_result, 2) && busy ##2 !busy)
      else $error("parallel data not ahead of busy fall");
  a_bus_oe:
    assert property ($changed(par_req) |=> par_oe == $past(par_req))
      else $error("parallel bus enable late");
  a_chan_swap:
    assert property ($fell(chan_read_sel) && !b_done |=> par_data == res_b)
      else $error("channel B not presented");
  a_sync_busy:
    assert property ($fell(sync_out) && cst == C_TAIL && ccnt == '0 |-> busy [*3] ##1 !busy)
      else $error("busy did not follow frame sync");
  a_cs_float:
    assert property (cs_n |-> !sync_oe && !sclk_oe && !serial_result_out_oe)
      else $error("serial pins driven with chip select high");
  a_pair_latch:
    assert property (start |=> pair_sel == $past(ctrl[CTRL_PAIR_BIT]))
      else $error("input pair not latched at start");
endmodule // dcs_sequencer

// file: testbench/dcs_host_model.sv
// host-side receiver of the master serial frame
// assumes frame sync, serial clock and data all change on clk edges
`timescale 1ns/1ns
module dcs_host_model
  import dcs_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic sync_out,
  input wire logic sclk_out,
  input wire logic serial_result_out,
  output logic [31:0] word,
  output int nbits,
  output int period,
  output int lead
);
  logic psync;
  logic psclk;
  int pc;
  int lc;
  wire rise = sync_out && sclk_out && !psclk;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      psync <= 1'b0;
      psclk <= 1'b0;
      word <= 32'h0;
      nbits <= 0;
      period <= 0;
      lead <= 0;
      pc <= 0;
      lc <= 0;
    end else begin
      psync <= sync_out;
      psclk <= sclk_out;
      pc <= rise ? 1 : pc + 1;
      lc <= (sync_out && !psync) ? 1 : lc + 1;
      if (sync_out && !psync) begin
        nbits <= 0;
      end
      // data is taken on the rising serial clock, only inside a frame
      if (rise) begin
        word <= {word[30:0], serial_result_out};
        nbits <= nbits + 1;
        period <= pc;
        if (nbits == 0) begin
          lead <= lc;
        end
      end
    end
  end
endmodule // dcs_host_model

// file: testbench/dcs_sequencer_tb.sv
// self-checking bench of the conversion sequencer
// assumes the host model above reads master serial frames
`timescale 1ns/1ns
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  $display("wrong value %s expected %0h seen %0h", n, e, g); err_count++; end end
module dcs_sequencer_tb;
  import dcs_pkg::*;
  logic clk, rstn, convert_start_n, cs_n, rd_n, chan_read_sel, ext_sclk;
  logic busy, eoc, pair_sel, par_oe, sync_out, sync_oe, sclk_out, sclk_oe, serial_result_out, serial_result_out_oe;
  logic [15:0] ca, cb, par_data, ph0, ph1, ph2;
  logic [31:0] q, word;
  logic [7:0] ctrl;
  dcs_wb_req_s wb_i;
  dcs_wb_rsp_s wb_o;
  int err_count, samples_checked, seed, t, tb, te, ts, tsf, tbf, teb, ea, eb, gap, nbits, period, lead;
  int lim_n[4] = '{3250, 4250, 6250, 10750};
  int lim_lp[4] = '{3500, 4500, 6500, 11000};
  int min_p[4] = '{25, 50, 100, 200};
  dcs_sequencer dcs_sequencer_inst (.clk(clk), .rstn(rstn), .ce(1'b1), .wb_i(wb_i), .wb_o(wb_o),
    .convert_start_n(convert_start_n), .conv_reset(1'b0), .cs_n(cs_n), .rd_n(rd_n),
    .chan_read_sel(chan_read_sel), .ext_sclk(ext_sclk), .serial_chain_in(1'b0), .core_a_result(ca),
    .core_b_result(cb), .busy(busy), .eoc(eoc), .pair_sel(pair_sel), .sample_hold(), .par_data(par_data),
    .par_oe(par_oe), .sync_out(sync_out), .sync_oe(sync_oe), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
    .serial_result_out(serial_result_out), .serial_result_out_oe(serial_result_out_oe));
  dcs_host_model dcs_host_model_inst (.clk(clk), .rstn(rstn), .sync_out(sync_out), .sclk_out(sclk_out),
    .serial_result_out(serial_result_out), .word(word), .nbits(nbits), .period(period), .lead(lead));
  function automatic logic [31:0] order(input logic s, input logic [15:0] a, input logic [15:0] b);
    return s ? {a, b} : {b, a};
  endfunction
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a, dat: d};
    // ack and read data are taken at the very edge that samples ack high
    do begin
      @(posedge clk);
      n++;
    end while (wb_o.ack !== 1'b1 && n < 50);
    r = wb_o.dat;
    if (n >= 50) err_count++;
    wb_i <= '0;
  endtask
  task automatic setup(input logic [7:0] c);
    ctrl = c;
    wb(1'b1, REG_CTRL, {24'h0, c}, q);
    wb(1'b0, REG_CTRL, 32'h0, q);
    `CHK("ctrl", {24'h0, c}, q)
    ca <= 16'($random(seed));
    cb <= 16'($random(seed));
    chan_read_sel <= 1'($random(seed));
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    repeat (30) @(posedge clk);
  endtask
  task automatic conv();
    logic pe, ps;
    int nf;
    tb = 0; te = 0; ts = 0; tsf = 0; tbf = 0; teb = 0; ea = 0; eb = 0; gap = 0; nf = 0; t = 0;
    pe = 0; ps = 0;
    @(posedge clk);
    convert_start_n <= 1'b0;
    while (tbf == 0 && t < 1500) begin
      @(posedge clk);
      if (t == 2) convert_start_n <= 1'b1;
      t++;
      if (busy && tb == 0) tb = t;
      if (eoc && te == 0) te = t;
      if (pe && !eoc) nf++;
      if (pe && !eoc && nf == 2) teb = t;
      if (eoc && nf == 0) ea++;
      if (eoc && nf == 1) eb++;
      if (!eoc && nf == 1) gap++;
      if (sync_out && !ps) ts = t;
      if (!sync_out && ps) tsf = t;
      if (tb != 0 && !busy) tbf = t;
      ph2 = ph1; ph1 = ph0; ph0 = par_data;
      pe = eoc; ps = sync_out;
    end
    `CHK("busy rise", 1'b1, tb > 0 && tb * 10 <= 32)
    `CHK("eoc rise", 1'b1, te > 0 && te * 10 <= 30)
    `CHK("eoc a", 1'b1, ea > 0 && ea * 10 <= (ctrl[1] ? 1250 : 1000))
    `CHK("eoc gap", 1'b1, gap * 10 >= 45)
    `CHK("eoc b", 1'b1, eb > 0 && eb * 10 <= 750)
    `CHK("busy fall", 1'b1, teb > 0 && tbf > 0 && (tbf - teb) * 10 >= 10)
    `CHK("pair", ctrl[6], pair_sel)
    if (!(ctrl[0] && ctrl[3])) `CHK("busy width", 1'b1, (tbf - tb) * 10 <= (ctrl[1] ? 2000 : 1750))
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #300000;
    err_count++;
    results();
  end
  initial begin
    seed = 37; err_count = 0; samples_checked = 0;
    rstn = 1'b0; convert_start_n = 1'b1; cs_n = 1'b1; rd_n = 1'b1; chan_read_sel = 1'b1;
    wb_i = '0; ca = 16'h0; cb = 16'h0;
    ext_sclk = 1'b0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    wb(1'b0, REG_CTRL, 32'h0, q);
    `CHK("ctrl reset", {24'h0, CTRL_RESET}, q)
    wb(1'b1, 8'h10, 32'hffffffff, q);
    wb(1'b0, 8'h10, 32'h0, q);
    `CHK("unmapped", 32'h0, q)
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      setup({1'b0, 1'($random(seed)), 4'h0, i[0], 1'b0});
      chan_read_sel <= 1'b1;
      conv();
      `CHK("par data", ca, ph2)
      `CHK("par oe", 1'b1, par_oe)
      `CHK("serial_result_out oe", 1'b0, serial_result_out_oe)
      chan_read_sel <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      `CHK("par other", cb, par_data)
      @(posedge clk);
      rd_n <= 1'b1;
      @(posedge clk);
      #1;
      `CHK("par release", 1'b0, par_oe)
    end
    $display("test parallel done");
    for (int i = 0; i < 8; i++) begin
      setup({1'b0, 1'($random(seed)), 2'(i / 2), 2'b10, 1'(i), 1'b1});
      conv();
      `CHK("sync rac", 1'b1, ts * 10 - (ctrl[1] ? 1000 : 750) inside {[-20:20]})
      `CHK("sync busy", 1'b1, (tbf - tsf) * 10 - 25 inside {[-10:10]})
      `CHK("sclk min", 1'b1, period * 10 >= min_p[i / 2])
      `CHK("sclk typ", SCLK_NS[i / 2], period * 10)
      `CHK("lead", 1'b1, lead * 10 >= (i / 2 == 0 ? 3 : 17))
      `CHK("bits", 32, nbits)
      `CHK("word", order(chan_read_sel, ca, cb), word)
      `CHK("rac busy", 1'b1, (tbf - tb) * 10 <= (ctrl[1] ? lim_lp[i / 2] : lim_n[i / 2]))
      `CHK("oe on", 3'b111, {sync_oe, sclk_oe, serial_result_out_oe})
      `CHK("par off", 1'b0, par_oe)
      cs_n <= 1'b1;
      @(posedge clk);
      #1;
      `CHK("oe off", 3'b000, {sync_oe, sclk_oe, serial_result_out_oe})
    end
    $display("test read after convert done");
    for (int i = 0; i < 2; i++) begin
      setup({6'h0, 1'(i), 1'b1});
      conv();
      `CHK("sync rdc", 1'b1, ts * 10 - (i ? 500 : 250) inside {[-20:20]})
      `CHK("sync busy", 1'b1, (tbf - tsf) * 10 - 25 inside {[-10:10]})
    end
    $display("test read during convert done");
    for (int i = 0; i < 2; i++) begin
      setup({1'b0, 1'($random(seed)), 3'h0, 1'b1, 1'(i), 1'b1});
      conv();
      `CHK("slave oe", 3'b001, {sync_oe, sclk_oe, serial_result_out_oe})
      q = 32'h0;
      // host clock at three system cycles a bit, one cycle high
      for (int k = 0; k < 32; k++) begin
        q = {q[30:0], serial_result_out};
        ext_sclk <= 1'b1;
        @(posedge clk);
        ext_sclk <= 1'b0;
        repeat (2) @(posedge clk);
      end
      `CHK("slave word", order(chan_read_sel, ca, cb), q)
    end
    $display("test slave serial done");
    results();
  end
endmodule // dcs_sequencer_tb
